// File: src/cpic_pkg.sv
// Constants, types and shared functions of the cascaded interrupt controller pair.
// Assumes a single clock; index 0 is the primary controller, 1 the secondary.
package cpic_pkg;
	// Reset and initialization values
	localparam logic [7:0] CPIC_MASK_RST = 8'h00;
	localparam logic [2:0] CPIC_LOW_RST = 3'h7;
	localparam logic [7:0] CPIC_CASC_RST = 8'h07;
	localparam logic [4:0] CPIC_BASE_RST = 5'h00;
	localparam logic [7:0] CPIC_MODE_RST = 8'h00;
	localparam logic [2:0] CPIC_DEFAULT_LVL = 3'h7;
	// Inputs whose trigger style is fixed to edge (inputs 0, 2 and 8)
	localparam logic [15:0] CPIC_TRIG_ALLOWED = 16'hfefa;
	// Field positions of the command bytes
	localparam int CPIC_START_BIT = 4;
	localparam int CPIC_SEL3_BIT = 3;
	localparam int CPIC_POLL_BIT = 2;
	localparam int CPIC_RR_BIT = 1;
	localparam int CPIC_RIS_BIT = 0;
	localparam int CPIC_SELECTIVE_MASK_ENABLE_BIT_BIT = 6;
	localparam int CPIC_SMM_BIT = 5;
	localparam int CPIC_AUTO_COMPLETION_MODE_BIT = 1;
	localparam int CPIC_SFNM_BIT = 4;
	localparam int CPIC_BASE_LO = 3;
	localparam int CPIC_CMD_LO = 5;
	localparam int CPIC_POLL_FOUND_BIT = 7;
	// Codes of the rotate command field
	typedef enum logic [2:0] {
		CPIC_CMD_ROT_AUTO_COMPLETION_MODE_CLR = 3'h0,
		CPIC_CMD_NS_EOI = 3'h1,
		CPIC_CMD_NOP = 3'h2,
		CPIC_CMD_SP_EOI = 3'h3,
		CPIC_CMD_ROT_AUTO_COMPLETION_MODE_SET = 3'h4,
		CPIC_CMD_ROT_NS_EOI = 3'h5,
		CPIC_CMD_SET_PRIO = 3'h6,
		CPIC_CMD_ROT_SP_EOI = 3'h7
	} cpic_cmd_type;
	// Initialization sequence, Gray coded
	typedef enum logic [1:0] {
		CPIC_INIT_IDLE = 2'b00,
		CPIC_INIT_BASE = 2'b01,
		CPIC_INIT_CASC = 2'b11,
		CPIC_INIT_MODE = 2'b10
	} cpic_init_type;
	// Acknowledge pulse phase
	typedef enum logic {
		CPIC_ACK_FIRST = 1'b0,
		CPIC_ACK_SECOND = 1'b1
	} cpic_ack_type;
	// Highest-priority set bit under rotation: {found, level}
	function automatic logic [3:0] cpic_first(input logic [7:0] v, input logic [2:0] low);
		logic [3:0] r;
		logic [2:0] l;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			l = low + 3'(i) + 3'h1;
			if (v[l]) r = {1'b1, l};
		end
		return r;
	endfunction : cpic_first
	// Rank of a level, 0 being the highest priority
	function automatic logic [2:0] cpic_pos(input logic [2:0] l, input logic [2:0] low);
		return 3'(l - low - 3'h1);
	endfunction : cpic_pos
endpackage : cpic_pkg

// File: src/cpic_ctl_if.sv
// Control and status bundle between the port logic and one controller core.
// Assumes all signals are synchronous to the block clock.
`timescale 1ns/1ps
interface cpic_ctl_if;
	logic init;
	logic freeze;
	logic ack_take;
	logic auto_eoi;
	logic cmd_valid;
	logic selective_mask_mode;
	logic sfnm;
	logic [2:0] cmd;
	logic [2:0] lvl;
	logic [7:0] irq;
	logic [7:0] trig;
	logic [7:0] mask;
	logic [7:0] casc;
	logic req;
	logic [3:0] win;
	logic [7:0] pending_request_bits;
	logic [7:0] in_service_bits;
	modport ctl(output init, freeze, ack_take, auto_eoi, cmd_valid, selective_mask_mode, sfnm, cmd, lvl, irq,
		trig, mask, casc, input req, win, pending_request_bits, in_service_bits);
	modport core(input init, freeze, ack_take, auto_eoi, cmd_valid, selective_mask_mode, sfnm, cmd, lvl, irq,
		trig, mask, casc, output req, win, pending_request_bits, in_service_bits);
endinterface : cpic_ctl_if

// File: src/cpic_core.sv
// One eight-input controller: request capture, priority, in-service and rotation.
// Assumes the port logic in the top module issues commands as one-cycle strobes.
`timescale 1ns/1ps
module cpic_core (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Control bundle
	cpic_ctl_if.core c
);
	logic [7:0] irr_r, irr_nxt, isr_r, isr_nxt, prev_r, prev_nxt, blk;
	logic [2:0] low_r, low_nxt;
	logic rot_r, rot_nxt, do_ns, do_rot;
	logic [3:0] win, top, ns;

	// Arbitration against in-service levels
	always_comb begin
		win = cpic_pkg::cpic_first(irr_r & ~c.mask, low_r);
		blk = c.selective_mask_mode ? 8'h00 : (c.sfnm ? (isr_r & ~c.casc) : isr_r);
		top = cpic_pkg::cpic_first(blk, low_r);
		c.req = win[3] && (!top[3] ||
			cpic_pkg::cpic_pos(win[2:0], low_r) < cpic_pkg::cpic_pos(top[2:0], low_r));
		c.win = win;
		c.pending_request_bits = irr_r;
		c.in_service_bits = isr_r;
		ns = cpic_pkg::cpic_first(c.selective_mask_mode ? (isr_r & ~c.mask) : isr_r, low_r);
	end

	// Next request, service and priority state
	always_comb begin
		prev_nxt = c.irq;
		irr_nxt = irr_r;
		isr_nxt = isr_r;
		low_nxt = low_r;
		rot_nxt = rot_r;
		do_ns = c.auto_eoi || (c.cmd_valid && (c.cmd == cpic_pkg::CPIC_CMD_NS_EOI ||
			c.cmd == cpic_pkg::CPIC_CMD_ROT_NS_EOI));
		do_rot = c.auto_eoi ? rot_r : (c.cmd == cpic_pkg::CPIC_CMD_ROT_NS_EOI);
		// Edge inputs drop their request when the line falls
		if (!c.freeze) begin
			irr_nxt = (c.trig & c.irq) | (~c.trig & c.irq & (irr_r | (c.irq & ~prev_r)));
		end
		if (c.ack_take && c.req) begin
			isr_nxt[win[2:0]] = 1'b1;
			irr_nxt[win[2:0]] = 1'b0;
		end
		if (do_ns && ns[3]) begin
			isr_nxt[ns[2:0]] = 1'b0;
			if (do_rot) low_nxt = ns[2:0];
		end
		if (c.cmd_valid && !c.auto_eoi) begin
			case (c.cmd)
				cpic_pkg::CPIC_CMD_SP_EOI: isr_nxt[c.lvl] = 1'b0;
				cpic_pkg::CPIC_CMD_ROT_SP_EOI: begin
					isr_nxt[c.lvl] = 1'b0;
					low_nxt = c.lvl;
				end
				cpic_pkg::CPIC_CMD_SET_PRIO: low_nxt = c.lvl;
				cpic_pkg::CPIC_CMD_ROT_AUTO_COMPLETION_MODE_SET: rot_nxt = 1'b1;
				cpic_pkg::CPIC_CMD_ROT_AUTO_COMPLETION_MODE_CLR: rot_nxt = 1'b0;
				default: rot_nxt = rot_r;
			endcase
		end
		// Initialization makes edge inputs need a fresh rising edge afterwards
		if (c.init) begin
			irr_nxt = 8'h00;
			isr_nxt = 8'h00;
			prev_nxt = 8'hff;
			low_nxt = cpic_pkg::CPIC_LOW_RST;
			rot_nxt = 1'b0;
		end
	end

	// State registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			irr_r <= 8'h00;
			isr_r <= 8'h00;
			prev_r <= 8'hff;
			low_r <= cpic_pkg::CPIC_LOW_RST;
			rot_r <= 1'b0;
		end else begin
			irr_r <= irr_nxt;
			isr_r <= isr_nxt;
			prev_r <= prev_nxt;
			low_r <= low_nxt;
			rot_r <= rot_nxt;
		end
	end

	property p_set_prio;
		@(posedge clk_i) disable iff (reset_i)
		c.cmd_valid && !c.auto_eoi && !c.init && !c.ack_take && c.cmd == cpic_pkg::CPIC_CMD_SET_PRIO
		|=> low_r == $past(c.lvl) && isr_r == $past(isr_r);
	endproperty
	a_set_prio: assert property (p_set_prio) else $error("set priority wrong");
	property p_rot_sp;
		@(posedge clk_i) disable iff (reset_i)
		c.cmd_valid && !c.auto_eoi && !c.init && c.cmd == cpic_pkg::CPIC_CMD_ROT_SP_EOI
		|=> !isr_r[$past(c.lvl)] && low_r == $past(c.lvl);
	endproperty
	a_rot_sp: assert property (p_rot_sp) else $error("rotate specific wrong");
	property p_rot_ns;
		@(posedge clk_i) disable iff (reset_i)
		do_ns && do_rot && ns[3] && !c.init && !c.cmd_valid |=> low_r == $past(ns[2:0]);
	endproperty
	a_rot_ns: assert property (p_rot_ns) else $error("auto rotation wrong");
	property p_hold_isr;
		@(posedge clk_i) disable iff (reset_i)
		!c.init && !do_ns && !c.cmd_valid ##1 !c.init && !do_ns && !c.cmd_valid
		|=> (isr_r & $past(isr_r, 2)) == $past(isr_r, 2);
	endproperty
	a_hold_isr: assert property (p_hold_isr) else $error("in-service bit lost");
	property p_masked;
		@(posedge clk_i) disable iff (reset_i)
		c.req |-> !c.mask[win[2:0]] && irr_r[win[2:0]];
	endproperty
	a_masked: assert property (p_masked) else $error("masked level requested");
	property p_init;
		@(posedge clk_i) disable iff (reset_i)
		c.init |=> low_r == cpic_pkg::CPIC_LOW_RST && isr_r == 8'h00 && irr_r == 8'h00;
	endproperty
	a_init: assert property (p_init) else $error("init state wrong");
endmodule : cpic_core

// File: src/cpic_top.sv
// Overview of operation
// - Vector bits 7:3 come from each controller's own base byte.
// - Secondary answers only when broadcast code matches its identity byte.
// - Levels ranked 0 highest to 7; winner's vector returned.
// - In-service bit held until completion; blocks equal and lower levels.
// - Special nested mode lets higher secondary requests through past its in-service bit.
// - Automatic rotation gives serviced level lowest priority, codes 101 and 100.
// - Set priority makes named level bottom, in-service untouched.
// - Rotate-specific completion clears named level and makes it bottom.
// - Poll bit freezes requests; next read acts as acknowledge.
// - Poll byte: bit 7 request present, bits 2:0 level.
// - Global level-trigger bit ignored; per-input select used.
// - Request gone by first pulse returns default level 7 vector.
// - Non-specific completion clears top in-service bit; specific clears named.
// - Special mask mode: masked in-service bits survive non-specific completion.
// - Automatic completion clears top in-service bit at second pulse.
// - Mask bit blocks its channel; primary input 2 blocks the secondary.
// - Vector low bits are the input number inside the answering controller.
// - First pulse sets in-service, clears request, broadcasts identity code.
// - Base-port write with bit 4 starts three-byte initialization.
// - Initialization clears mask, level 7 lowest, identity 7, mask mode off.
// Top of the cascaded pair: command ports, acknowledge sequencing and readback.
// Assumes port accesses and acknowledge strobes are synchronous single-cycle events.
`timescale 1ns/1ps
module cpic_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Port writes: sel 0 primary, 1 secondary; addr 0 base, 1 data
	input wire logic wr_en_i,
	input wire logic wr_sel_i,
	input wire logic wr_addr_i,
	input wire logic [7:0] wr_data_i,
	// Port reads
	input wire logic rd_en_i,
	input wire logic rd_sel_i,
	input wire logic rd_addr_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	// Request lines and per-input trigger style
	input wire logic [15:0] irq_i,
	input wire logic [15:0] trigger_style_select_i,
	// Processor side
	input wire logic internal_ack_pulse_i,
	output logic cpu_request_out_o,
	output logic [7:0] vector_o,
	output logic vector_valid_o
);
	cpic_pkg::cpic_init_type st_r [2];
	cpic_pkg::cpic_init_type st_nxt [2];
	logic [1:0][4:0] base_r, base_nxt;
	logic [1:0][7:0] casc_r, casc_nxt, mode_r, mode_nxt, mask_r, mask_nxt;
	logic [1:0] smm_r, smm_nxt, rdisr_r, rdisr_nxt, poll_r, poll_nxt;
	logic [1:0] init_s, cmd_s, poll_rd, ack_s, auto_completion_mode_s;
	logic [1:0][7:0] irq_s, irr_s, isr_s;
	logic [1:0][3:0] win_s;
	logic [1:0] req_s;
	cpic_pkg::cpic_ack_type phase_r, phase_nxt;
	logic sec_resp_r, sec_resp_nxt, p_ok_r, p_ok_nxt, s_ok_r, s_ok_nxt;
	logic [2:0] p_lvl_r, p_lvl_nxt, s_lvl_r, s_lvl_nxt, id_r, id_nxt;
	logic first_ack, second_ack, casc_hit;
	logic [7:0] vec_nxt, rd_nxt;
	logic vec_v_nxt, rd_v_nxt, cpu_nxt;
	logic [15:0] trig;

	// Fixed-edge inputs cannot be switched to level
	assign trig = trigger_style_select_i & cpic_pkg::CPIC_TRIG_ALLOWED;
	// Primary input 2 carries the secondary request
	assign irq_s[1] = irq_i[15:8];
	assign irq_s[0] = {irq_i[7:3], req_s[1], irq_i[1:0]};

	// Two controller cores
	for (genvar k = 0; k < 2; k++) begin : g_ctl
		cpic_ctl_if cif ();
		cpic_core u_core (
			.clk_i(clk_i),
			.reset_i(reset_i),
			.c(cif.core)
		);
		assign cif.init = init_s[k];
		assign cif.freeze = poll_r[k];
		assign cif.ack_take = ack_s[k];
		assign cif.auto_eoi = auto_completion_mode_s[k];
		assign cif.cmd_valid = cmd_s[k];
		assign cif.selective_mask_mode = smm_r[k];
		assign cif.sfnm = mode_r[k][cpic_pkg::CPIC_SFNM_BIT];
		assign cif.cmd = wr_data_i[7:cpic_pkg::CPIC_CMD_LO];
		assign cif.lvl = wr_data_i[2:0];
		assign cif.irq = irq_s[k];
		assign cif.trig = trig[8*k +: 8];
		assign cif.mask = mask_r[k];
		assign cif.casc = casc_r[k];
		assign req_s[k] = cif.req;
		assign win_s[k] = cif.win;
		assign irr_s[k] = cif.pending_request_bits;
		assign isr_s[k] = cif.in_service_bits;
	end

	// Command byte decode and initialization sequence
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			st_nxt[k] = st_r[k];
			base_nxt[k] = base_r[k];
			casc_nxt[k] = casc_r[k];
			mode_nxt[k] = mode_r[k];
			mask_nxt[k] = mask_r[k];
			smm_nxt[k] = smm_r[k];
			rdisr_nxt[k] = rdisr_r[k];
			poll_nxt[k] = poll_r[k];
			init_s[k] = 1'b0;
			cmd_s[k] = 1'b0;
			poll_rd[k] = rd_en_i && (rd_sel_i == 1'(k)) && !rd_addr_i && poll_r[k];
			if (poll_rd[k]) poll_nxt[k] = 1'b0;
			if (wr_en_i && (wr_sel_i == 1'(k))) begin
				if (!wr_addr_i) begin
					// Global level-trigger bit 3 is not used
					if (wr_data_i[cpic_pkg::CPIC_START_BIT]) begin
						init_s[k] = 1'b1;
						st_nxt[k] = cpic_pkg::CPIC_INIT_BASE;
						mask_nxt[k] = cpic_pkg::CPIC_MASK_RST;
						casc_nxt[k] = cpic_pkg::CPIC_CASC_RST;
						smm_nxt[k] = 1'b0;
						rdisr_nxt[k] = 1'b0;
						poll_nxt[k] = 1'b0;
					end else if (wr_data_i[cpic_pkg::CPIC_SEL3_BIT]) begin
						poll_nxt[k] = wr_data_i[cpic_pkg::CPIC_POLL_BIT];
						if (wr_data_i[cpic_pkg::CPIC_RR_BIT]) begin
							rdisr_nxt[k] = wr_data_i[cpic_pkg::CPIC_RIS_BIT];
						end
						if (wr_data_i[cpic_pkg::CPIC_SELECTIVE_MASK_ENABLE_BIT_BIT]) begin
							smm_nxt[k] = wr_data_i[cpic_pkg::CPIC_SMM_BIT];
						end
					end else begin
						cmd_s[k] = 1'b1;
					end
				end else begin
					case (st_r[k])
						cpic_pkg::CPIC_INIT_BASE: begin
							base_nxt[k] = wr_data_i[7:cpic_pkg::CPIC_BASE_LO];
							st_nxt[k] = cpic_pkg::CPIC_INIT_CASC;
						end
						cpic_pkg::CPIC_INIT_CASC: begin
							casc_nxt[k] = wr_data_i;
							st_nxt[k] = cpic_pkg::CPIC_INIT_MODE;
						end
						cpic_pkg::CPIC_INIT_MODE: begin
							mode_nxt[k] = wr_data_i;
							st_nxt[k] = cpic_pkg::CPIC_INIT_IDLE;
						end
						default: mask_nxt[k] = wr_data_i;
					endcase
				end
			end
		end
	end

	// Acknowledge sequencing and vector selection
	always_comb begin
		first_ack = internal_ack_pulse_i && (phase_r == cpic_pkg::CPIC_ACK_FIRST);
		second_ack = internal_ack_pulse_i && (phase_r == cpic_pkg::CPIC_ACK_SECOND);
		casc_hit = req_s[0] && casc_r[0][win_s[0][2:0]] &&
			(win_s[0][2:0] == casc_r[1][2:0]);
		ack_s[0] = first_ack || poll_rd[0];
		ack_s[1] = (first_ack && casc_hit) || poll_rd[1];
		auto_completion_mode_s[0] = second_ack && p_ok_r && mode_r[0][cpic_pkg::CPIC_AUTO_COMPLETION_MODE_BIT];
		auto_completion_mode_s[1] = second_ack && sec_resp_r && s_ok_r && mode_r[1][cpic_pkg::CPIC_AUTO_COMPLETION_MODE_BIT];
		phase_nxt = phase_r;
		sec_resp_nxt = sec_resp_r;
		p_ok_nxt = p_ok_r;
		p_lvl_nxt = p_lvl_r;
		s_ok_nxt = s_ok_r;
		s_lvl_nxt = s_lvl_r;
		id_nxt = id_r;
		vec_nxt = vector_o;
		vec_v_nxt = 1'b0;
		if (first_ack) begin
			phase_nxt = cpic_pkg::CPIC_ACK_SECOND;
			p_ok_nxt = req_s[0];
			p_lvl_nxt = win_s[0][2:0];
			id_nxt = win_s[0][2:0];
			sec_resp_nxt = casc_hit;
			s_ok_nxt = req_s[1];
			s_lvl_nxt = win_s[1][2:0];
		end
		if (second_ack) begin
			phase_nxt = cpic_pkg::CPIC_ACK_FIRST;
			vec_v_nxt = 1'b1;
			if (sec_resp_r) begin
				vec_nxt = {base_r[1], s_ok_r ? s_lvl_r : cpic_pkg::CPIC_DEFAULT_LVL};
			end else begin
				vec_nxt = {base_r[0], p_ok_r ? p_lvl_r : cpic_pkg::CPIC_DEFAULT_LVL};
			end
		end
		// Request to the processor drops while an acknowledge is under way
		cpu_nxt = req_s[0] && (phase_nxt == cpic_pkg::CPIC_ACK_FIRST) && !first_ack;
	end

	// Port readback
	always_comb begin
		rd_nxt = rd_data_o;
		rd_v_nxt = 1'b0;
		if (rd_en_i) begin
			rd_v_nxt = 1'b1;
			if (rd_addr_i) begin
				rd_nxt = mask_r[rd_sel_i];
			end else if (poll_r[rd_sel_i]) begin
				rd_nxt = {req_s[rd_sel_i], 4'h0, win_s[rd_sel_i][2:0]};
			end else begin
				rd_nxt = rdisr_r[rd_sel_i] ? isr_s[rd_sel_i] : irr_s[rd_sel_i];
			end
		end
	end

	// Registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int k = 0; k < 2; k++) begin
				st_r[k] <= cpic_pkg::CPIC_INIT_IDLE;
			end
			base_r <= {2{cpic_pkg::CPIC_BASE_RST}};
			casc_r <= {2{cpic_pkg::CPIC_CASC_RST}};
			mode_r <= {2{cpic_pkg::CPIC_MODE_RST}};
			mask_r <= {2{cpic_pkg::CPIC_MASK_RST}};
			smm_r <= 2'h0;
			rdisr_r <= 2'h0;
			poll_r <= 2'h0;
			phase_r <= cpic_pkg::CPIC_ACK_FIRST;
			sec_resp_r <= 1'b0;
			p_ok_r <= 1'b0;
			p_lvl_r <= 3'h0;
			s_ok_r <= 1'b0;
			s_lvl_r <= 3'h0;
			id_r <= 3'h0;
			vector_o <= 8'h00;
			vector_valid_o <= 1'b0;
			rd_data_o <= 8'h00;
			rd_valid_o <= 1'b0;
			cpu_request_out_o <= 1'b0;
		end else begin
			st_r <= st_nxt;
			base_r <= base_nxt;
			casc_r <= casc_nxt;
			mode_r <= mode_nxt;
			mask_r <= mask_nxt;
			smm_r <= smm_nxt;
			rdisr_r <= rdisr_nxt;
			poll_r <= poll_nxt;
			phase_r <= phase_nxt;
			sec_resp_r <= sec_resp_nxt;
			p_ok_r <= p_ok_nxt;
			p_lvl_r <= p_lvl_nxt;
			s_ok_r <= s_ok_nxt;
			s_lvl_r <= s_lvl_nxt;
			id_r <= id_nxt;
			vector_o <= vec_nxt;
			vector_valid_o <= vec_v_nxt;
			rd_data_o <= rd_nxt;
			rd_valid_o <= rd_v_nxt;
			cpu_request_out_o <= cpu_nxt;
		end
	end

	property p_prim_vec;
		@(posedge clk_i) disable iff (reset_i)
		second_ack && !sec_resp_r && p_ok_r |=> vector_valid_o && vector_o == {$past(base_r[0]),
			$past(p_lvl_r)};
	endproperty
	a_prim_vec: assert property (p_prim_vec) else $error("primary vector wrong");
	property p_sec_vec;
		@(posedge clk_i) disable iff (reset_i)
		second_ack && sec_resp_r |=> vector_o[7:3] == $past(base_r[1]);
	endproperty
	a_sec_vec: assert property (p_sec_vec) else $error("secondary base wrong");
	property p_default;
		@(posedge clk_i) disable iff (reset_i)
		second_ack && !sec_resp_r && !p_ok_r |=> vector_valid_o &&
			vector_o == {$past(base_r[0]), 3'h7};
	endproperty
	a_default: assert property (p_default) else $error("default vector missing");
	property p_match;
		@(posedge clk_i) disable iff (reset_i)
		first_ack && casc_hit |=> sec_resp_r && id_r == casc_r[1][2:0];
	endproperty
	a_match: assert property (p_match) else $error("identity mismatch");
	property p_poll;
		@(posedge clk_i) disable iff (reset_i)
		poll_rd[0] && !rd_sel_i |=> rd_valid_o && rd_data_o[7] == $past(req_s[0]) &&
			rd_data_o[6:3] == 4'h0;
	endproperty
	a_poll: assert property (p_poll) else $error("poll byte wrong");
	property p_cpu;
		@(posedge clk_i) disable iff (reset_i)
		first_ack |=> !cpu_request_out_o [*1] ##1 !cpu_request_out_o || internal_ack_pulse_i;
	endproperty
	a_cpu: assert property (p_cpu) else $error("request not held off");
	property p_init_mask;
		@(posedge clk_i) disable iff (reset_i)
		init_s[0] |=> mask_r[0] == 8'h00 && !smm_r[0] && st_r[0] == cpic_pkg::CPIC_INIT_BASE;
	endproperty
	a_init_mask: assert property (p_init_mask) else $error("init clear wrong");
	property p_auto_completion_mode;
		@(posedge clk_i) disable iff (reset_i)
		auto_completion_mode_s[0] && isr_s[0] != 8'h00 && !smm_r[0] && !cmd_s[0] && !init_s[0]
		|=> $countones(isr_s[0]) == $countones($past(isr_s[0])) - 1;
	endproperty
	a_auto_completion_mode: assert property (p_auto_completion_mode) else $error("auto completion missed");
endmodule : cpic_top

// File: dv/cpic_host_model.sv
// Processor model: answers a go pulse with a pair of acknowledge strobes.
// Assumes the bench pulses go_i only once the previous vector has arrived.
`timescale 1ns/1ps
module cpic_host_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Bench control and controller side
	input wire logic go_i,
	input wire logic [7:0] vector_i,
	input wire logic vector_valid_i,
	output logic ack_o,
	output logic [7:0] vec_o,
	output logic done_o
);
	logic [2:0] cnt_r;
	// Two one-cycle strobes, two idle cycles apart
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cnt_r <= 3'h0;
			ack_o <= 1'b0;
		end else begin
			cnt_r <= go_i ? 3'h1 : ((cnt_r != 3'h0) ? cnt_r + 3'h1 : 3'h0);
			ack_o <= (cnt_r == 3'h1) || (cnt_r == 3'h4);
		end
	end
	// Capture of the returned vector
	always_ff @(posedge clk_i) begin
		if (reset_i || go_i) done_o <= 1'b0;
		else if (vector_valid_i) done_o <= 1'b1;
		if (vector_valid_i) vec_o <= vector_i;
	end
endmodule : cpic_host_model

// File: dv/cpic_top_tb.sv
// Self-checking bench of the cascaded controller pair.
// Assumes cpic_top and the host model; all inputs change by NBA at posedge.
`timescale 1ns/1ps
module cpic_top_tb;
	logic clk_i, reset_i, wr_en_i, wr_sel_i, wr_addr_i, rd_en_i, rd_sel_i, rd_addr_i;
	logic [7:0] wr_data_i, rd_data_o, vector_o, hvec;
	logic [15:0] irq_i, trigger_style_select_i;
	logic rd_valid_o, internal_ack_pulse_i, cpu_request_out_o, vector_valid_o, go, hdone;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	cpic_top cpic_top_i (.clk_i, .reset_i, .wr_en_i, .wr_sel_i, .wr_addr_i, .wr_data_i,
		.rd_en_i, .rd_sel_i, .rd_addr_i, .rd_data_o, .rd_valid_o, .irq_i,
		.trigger_style_select_i, .internal_ack_pulse_i, .cpu_request_out_o, .vector_o,
		.vector_valid_o);
	cpic_host_model cpic_host_model_i (.clk_i, .reset_i, .go_i(go), .vector_i(vector_o),
		.vector_valid_i(vector_valid_o), .ack_o(internal_ack_pulse_i), .vec_o(hvec),
		.done_o(hdone));
	// Clock and hang guard
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			results;
		end
	end
	task results;
		if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : cmp8
	task automatic cmp1(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %b seen %b", n, e, g);
		end
	endtask : cmp1
	// Bus cycles
	task automatic wr(input logic s, input logic a, input logic [7:0] d);
		@(posedge clk_i);
		wr_en_i <= 1'b1;
		wr_sel_i <= s;
		wr_addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic s, input logic a, input logic [7:0] e);
		@(posedge clk_i);
		rd_en_i <= 1'b1;
		rd_sel_i <= s;
		rd_addr_i <= a;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1;
		cmp1("rd_valid", 1'b1, rd_valid_o);
		cmp8("rd_data", e, rd_data_o);
	endtask : rd
	task automatic in_service_bits(input logic s, input logic [7:0] e);
		wr(s, 1'b0, 8'h0b);
		rd(s, 1'b0, e);
	endtask : in_service_bits
	task automatic setirq(input logic [15:0] v);
		@(posedge clk_i);
		irq_i <= v;
	endtask : setirq
	task automatic wreq(input logic e);
		int n;
		n = 0;
		#1;
		while (cpu_request_out_o !== e && n < 8) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		cmp1("cpu_request", e, cpu_request_out_o);
	endtask : wreq
	task automatic quiet;
		repeat (8) @(posedge clk_i);
		#1;
		cmp1("cpu_request", 1'b0, cpu_request_out_o);
	endtask : quiet
	task automatic ack(input logic [7:0] e);
		int n;
		n = 0;
		@(posedge clk_i);
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		#1;
		while (hdone !== 1'b1 && n < 30) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		cmp8("vector", e, hvec);
	endtask : ack
	task automatic init(input logic s, input logic [7:0] b, input logic [7:0] id);
		wr(s, 1'b0, 8'h19);
		wr(s, 1'b1, b);
		wr(s, 1'b1, id);
		wr(s, 1'b1, 8'h01);
	endtask : init
	// Scenarios
	task automatic t_init;
		rd(1'b0, 1'b1, 8'h00);
		init(1'b0, 8'h08, 8'h04);
		init(1'b1, 8'h70, 8'h02);
	endtask : t_init
	task automatic t_nested;
		setirq(16'h0028);
		wreq(1'b1);
		ack(8'h0b);
		quiet;
		setirq(16'h002a);
		wreq(1'b1);
		ack(8'h09);
		wr(1'b0, 1'b0, 8'h20);
		in_service_bits(1'b0, 8'h08);
		wr(1'b0, 1'b0, 8'h20);
		wreq(1'b1);
		ack(8'h0d);
		wr(1'b0, 1'b0, 8'h20);
		setirq(16'h0000);
		quiet;
	endtask : t_nested
	task automatic t_cascade;
		setirq(16'h1000);
		wreq(1'b1);
		ack(8'h74);
		in_service_bits(1'b1, 8'h10);
		wr(1'b1, 1'b0, 8'h20);
		in_service_bits(1'b1, 8'h00);
		wr(1'b0, 1'b0, 8'h20);
		setirq(16'h0000);
		wr(1'b0, 1'b1, 8'h04);
		setirq(16'h0200);
		quiet;
		wr(1'b0, 1'b1, 8'h00);
		wreq(1'b1);
		ack(8'h71);
		wr(1'b1, 1'b0, 8'h20);
		wr(1'b0, 1'b0, 8'h20);
		setirq(16'h0000);
		in_service_bits(1'b1, 8'h00);
	endtask : t_cascade
	task automatic t_poll;
		setirq(16'h0040);
		repeat (3) @(posedge clk_i);
		wr(1'b0, 1'b0, 8'h0c);
		rd(1'b0, 1'b0, 8'h86);
		in_service_bits(1'b0, 8'h40);
		wr(1'b0, 1'b0, 8'h66);
		in_service_bits(1'b0, 8'h00);
		setirq(16'h0000);
	endtask : t_poll
	task automatic t_prio;
		wr(1'b0, 1'b0, 8'hc4);
		in_service_bits(1'b0, 8'h00);
		setirq(16'h0028);
		wreq(1'b1);
		ack(8'h0d);
		wr(1'b0, 1'b0, 8'he5);
		in_service_bits(1'b0, 8'h00);
		ack(8'h0b);
		wr(1'b0, 1'b0, 8'h20);
		wr(1'b0, 1'b0, 8'hc7);
		setirq(16'h0000);
	endtask : t_prio
	task automatic t_level;
		@(posedge clk_i);
		trigger_style_select_i <= 16'h0020;
		setirq(16'h0020);
		wreq(1'b1);
		ack(8'h0d);
		wr(1'b0, 1'b0, 8'h20);
		wreq(1'b1);
		setirq(16'h0000);
		ack(8'h0f);
		wr(1'b0, 1'b0, 8'h20);
		quiet;
	endtask : t_level
	// Main sequence
	initial begin
		clk_i = 1'b0;
		reset_i = 1'b1;
		{wr_en_i, wr_sel_i, wr_addr_i, rd_en_i, rd_sel_i, rd_addr_i, go} = 7'h00;
		wr_data_i = 8'h00;
		irq_i = 16'h0000;
		trigger_style_select_i = 16'h0000;
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		t_init;
		t_nested;
		t_cascade;
		t_poll;
		t_prio;
		t_level;
		results;
	end
endmodule : cpic_top_tb
